/* rtl/nibble_alu_bit_test_decode.sv */
// Executes one ALU / bit-test instruction per command write.
// Assumes a classic Wishbone master; latch sets come from same-clock logic.
`timescale 1ns/1ps
module nibble_alu_bit_test_decode #(
   parameter logic [7:0] PORT_OUT_MASK = 8'hF0
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Wishbone slave
   input  wire logic              i_wb_cyc,
   input  wire logic              i_wb_stb,
   input  wire logic              i_wb_we,
   input  wire logic [11:0]       i_wb_adr,
   input  wire logic [3:0]        i_wb_sel,
   input  wire logic [31:0]       i_wb_dat,
   output logic      [31:0]       o_wb_dat,
   output logic                   o_wb_ack,
   // Interrupt latch set pulses
   input  wire logic [5:0]        i_latch_set,
   // Ports
   input  wire logic [31:0]       i_port_pin,
   output logic      [31:0]       o_port,
   // State view
   output logic                   o_busy,
   output nibble_pkg::flags_s     o_flags,
   output logic      [5:0]        o_int_latch,
   output logic                   o_ime
);
   nibble_pkg::state_e st_r;
   nibble_pkg::flags_s fl_r;
   nibble_pkg::flags_s fl_nxt;
   logic [7:0]  op_r;
   logic [7:0]  arg_r;
   logic [3:0]  acc_r;
   logic [3:0]  l_r;
   logic [3:0]  h_r;
   logic        ime_r;
   logic [5:0]  il_r;
   logic [31:0] port_r;
   logic [31:0] pin_m_r;
   logic [31:0] pin_s_r;
   logic        ph_r;
   logic [2:0]  mc_r;
   logic        wait_r;
   logic        ack_r;
   logic [31:0] dat_r;
   logic [4:0]  len_r;
   logic        idle;
   logic        two_cyc;
   logic        commit;
   logic [3:0]  mem_q;
   logic [3:0]  imm;
   logic [4:0]  sum_l;
   logic [4:0]  d_rc;
   logic [4:0]  d_sa;
   logic [4:0]  d_sm;
   logic [3:0]  res;
   logic [3:0]  acc_nxt;
   logic [3:0]  l_nxt;
   logic        ime_nxt;
   logic [5:0]  il_mask;
   logic [31:0] port_nxt;
   logic        mem_we_x;
   logic [3:0]  mem_wd;
   logic [3:0]  pval;
   logic [4:0]  l_idx;
   logic        ta_bit;
   logic        wb_fire;
   logic        wb_wr;
   logic        hit_mem;
   logic [31:0] rd_mux;
   logic [31:0] wmask_d;
   logic        ram_we;
   logic [7:0]  ram_waddr;
   logic [3:0]  ram_wdata;
   logic [7:0]  ram_raddr;

   assign idle  = (st_r == nibble_pkg::ST_IDLE);
   assign imm   = arg_r[3:0];
   assign l_idx = {1'b1, l_r};
   assign ta_bit = acc_r[op_r[1:0]];
   assign sum_l = {1'b0, l_r} + {1'b0, imm};
   assign d_rc  = {1'b0, mem_q} - {1'b0, acc_r} - {4'h0, ~fl_r.cf};
   assign d_sa  = {1'b0, imm} - {1'b0, acc_r};
   assign d_sm  = {1'b0, imm} - {1'b0, mem_q};
   // Output ports read back their register, the rest read the pin
   assign pval  = PORT_OUT_MASK[arg_r[2:0]] ? port_r[{arg_r[2:0], 2'b00} +: 4]
                                            : pin_s_r[{arg_r[2:0], 2'b00} +: 4];

   assign two_cyc = (op_r == nibble_pkg::OP_EXT) || (op_r == nibble_pkg::OP_PORTBIT)
                 || (op_r == nibble_pkg::OP_ILCLR) || (op_r == nibble_pkg::OP_TEST_L)
                 || (op_r == nibble_pkg::OP_SET_L) || (op_r == nibble_pkg::OP_CLR_L);
   // Last clock of the last machine cycle
   assign commit = !idle && ph_r && (mc_r == (two_cyc ? 3'd7 : 3'd3));

   // Execution datapath
   always_comb begin
      acc_nxt  = acc_r;
      l_nxt    = l_r;
      fl_nxt   = fl_r;
      ime_nxt  = ime_r;
      il_mask  = 6'h3F;
      port_nxt = port_r;
      mem_we_x = 1'b0;
      mem_wd   = mem_q;
      res      = 4'h0;
      case (op_r)
         nibble_pkg::OP_EXT: begin
            case (arg_r[7:4])
               nibble_pkg::X_ADDL: begin
                  l_nxt     = sum_l[3:0];
                  fl_nxt.zf = nibble_pkg::is_zero(sum_l[3:0]);
                  fl_nxt.sf = ~sum_l[4];
               end
               nibble_pkg::X_REVERSE_SUBTRACT_A: begin
                  acc_nxt   = d_sa[3:0];
                  fl_nxt.zf = nibble_pkg::is_zero(d_sa[3:0]);
                  fl_nxt.sf = ~d_sa[4];
               end
               nibble_pkg::X_REVERSE_SUBTRACT_M: begin
                  mem_we_x  = 1'b1;
                  mem_wd    = d_sm[3:0];
                  fl_nxt.zf = nibble_pkg::is_zero(d_sm[3:0]);
                  fl_nxt.sf = ~d_sm[4];
               end
               nibble_pkg::X_AND_A: begin
                  res       = acc_r & imm;
                  acc_nxt   = res;
                  fl_nxt.zf = nibble_pkg::is_zero(res);
                  fl_nxt.sf = ~nibble_pkg::is_zero(res);
               end
               nibble_pkg::X_OR_M: begin
                  res       = mem_q | imm;
                  mem_we_x  = 1'b1;
                  mem_wd    = res;
                  fl_nxt.zf = nibble_pkg::is_zero(res);
                  fl_nxt.sf = ~nibble_pkg::is_zero(res);
               end
               default: begin
               end
            endcase
         end
         nibble_pkg::OP_REVERSE_SUBTRACT_CARRY: begin
            acc_nxt   = d_rc[3:0];
            fl_nxt.cf = ~d_rc[4];
            fl_nxt.zf = nibble_pkg::is_zero(d_rc[3:0]);
            fl_nxt.sf = ~d_rc[4];
         end
         nibble_pkg::OP_OR_M, nibble_pkg::OP_XOR_M: begin
            res       = (op_r == nibble_pkg::OP_OR_M) ? (acc_r | mem_q)
                                                      : (acc_r ^ mem_q);
            acc_nxt   = res;
            fl_nxt.zf = nibble_pkg::is_zero(res);
            fl_nxt.sf = ~nibble_pkg::is_zero(res);
         end
         nibble_pkg::OP_ROTATE_LEFT_CARRY, nibble_pkg::OP_ROTATE_RIGHT_CARRY: begin
            res       = (op_r == nibble_pkg::OP_ROTATE_LEFT_CARRY) ? {acc_r[2:0], fl_r.cf}
                                                      : {fl_r.cf, acc_r[3:1]};
            fl_nxt.cf = (op_r == nibble_pkg::OP_ROTATE_LEFT_CARRY) ? acc_r[3] : acc_r[0];
            acc_nxt   = res;
            fl_nxt.zf = nibble_pkg::is_zero(res);
            fl_nxt.sf = ~fl_nxt.cf;
         end
         nibble_pkg::OP_PORTBIT: begin
            if (arg_r[7:6] == nibble_pkg::PB_INV) begin
               fl_nxt.sf = ~pval[arg_r[5:4]];
            end else if (arg_r[7:6] == nibble_pkg::PB_TRUE) begin
               fl_nxt.sf = pval[arg_r[5:4]];
            end
         end
         nibble_pkg::OP_TEST_L: begin
            fl_nxt.sf = ~pin_s_r[l_idx];
         end
         nibble_pkg::OP_TRUE_BIT_TEST_ZF: begin
            fl_nxt.sf = fl_r.zf;
         end
         nibble_pkg::OP_TRUE_BIT_TEST_GF: begin
            fl_nxt.sf = fl_r.gf;
         end
         nibble_pkg::OP_SET_GF, nibble_pkg::OP_CLR_GF: begin
            fl_nxt.gf = (op_r == nibble_pkg::OP_SET_GF);
            fl_nxt.sf = 1'b1;
         end
         nibble_pkg::OP_SET_L, nibble_pkg::OP_CLR_L: begin
            port_nxt[l_idx] = (op_r == nibble_pkg::OP_SET_L);
            fl_nxt.sf       = 1'b1;
         end
         nibble_pkg::OP_ILCLR: begin
            fl_nxt.sf = 1'b1;
            case (arg_r[7:6])
               nibble_pkg::IL_PLAIN: il_mask = arg_r[5:0];
               nibble_pkg::IL_EI: begin
                  il_mask = arg_r[5:0];
                  ime_nxt = 1'b1;
               end
               nibble_pkg::IL_DI: begin
                  il_mask = arg_r[5:0];
                  ime_nxt = 1'b0;
               end
               default: begin
               end
            endcase
         end
         default: begin
            if (op_r[7:2] == nibble_pkg::TA_PFX) begin
               fl_nxt.sf = ~ta_bit;
            end else if (op_r[7:2] == nibble_pkg::TM_PFX) begin
               fl_nxt.sf = ~mem_q[op_r[1:0]];
            end
         end
      endcase
   end

   // Sequencer: machine-cycle enable every second clock
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= nibble_pkg::ST_IDLE;
         ph_r <= 1'b0;
         mc_r <= 3'd0;
      end else begin
         case (st_r)
            nibble_pkg::ST_IDLE: begin
               ph_r <= 1'b0;
               mc_r <= 3'd0;
               if (wb_wr && (i_wb_adr == nibble_pkg::CMD_OFS)) begin
                  st_r <= nibble_pkg::ST_RUN;
               end
            end
            nibble_pkg::ST_RUN: begin
               ph_r <= ~ph_r;
               if (ph_r) begin
                  mc_r <= mc_r + 3'd1;
               end
               if (commit) begin
                  st_r <= nibble_pkg::ST_IDLE;
               end
            end
            default: st_r <= nibble_pkg::ST_IDLE;
         endcase
      end
   end

   // Core state: loaded by software when idle, all but H by the datapath at commit
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         acc_r <= 4'h0;
         l_r   <= 4'h0;
         h_r   <= 4'h0;
         fl_r  <= nibble_pkg::FLAGS_RST;
         ime_r <= 1'b0;
      end else if (commit) begin
         acc_r <= acc_nxt;
         l_r   <= l_nxt;
         fl_r  <= fl_nxt;
         ime_r <= ime_nxt;
      end else if (wb_wr && idle && (i_wb_adr == nibble_pkg::CORE_OFS)) begin
         acc_r <= wmask_d[3:0];
         l_r   <= wmask_d[nibble_pkg::CORE_L +: 4];
         h_r   <= wmask_d[nibble_pkg::CORE_H +: 4];
         fl_r  <= wmask_d[nibble_pkg::CORE_FLG +: 4];
         ime_r <= wmask_d[nibble_pkg::CORE_IME];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         op_r  <= 8'h00;
         arg_r <= 8'h00;
      end else if (wb_wr && idle && (i_wb_adr == nibble_pkg::CMD_OFS)) begin
         op_r  <= wmask_d[7:0];
         arg_r <= wmask_d[15:8];
      end
   end

   // A latch set in the clearing cycle survives
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         il_r <= 6'h00;
      end else if (commit) begin
         il_r <= (il_r & il_mask) | i_latch_set;
      end else begin
         il_r <= il_r | i_latch_set;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         port_r <= 32'h0000_0000;
      end else if (commit) begin
         port_r <= port_nxt;
      end else if (wb_wr && idle && (i_wb_adr == nibble_pkg::PORT_OFS)) begin
         port_r <= wmask_d;
      end
   end

   // Pin synchroniser
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_m_r <= 32'h0000_0000;
         pin_s_r <= 32'h0000_0000;
      end else begin
         pin_m_r <= i_port_pin;
         pin_s_r <= pin_m_r;
      end
   end

   // Wishbone: ack in the third cycle of a request so memory read data is ready
   // Writes land at the edge where the master samples ack, never earlier
   assign wb_fire = i_wb_cyc && i_wb_stb && ack_r;
   assign wb_wr   = wb_fire && i_wb_we;
   assign hit_mem = i_wb_adr[nibble_pkg::MEM_SEL_BIT];
   assign wmask_d = nibble_pkg::wmerge(rd_mux, i_wb_dat, i_wb_sel);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_mem) begin
         rd_mux = idle ? {28'h0, mem_q} : 32'h0000_0000;
      end else begin
         case (i_wb_adr)
            nibble_pkg::CMD_OFS:   rd_mux = {15'h0, !idle, arg_r, op_r};
            nibble_pkg::CORE_OFS:  rd_mux = {11'h0, ime_r, fl_r, 4'h0, h_r, l_r, acc_r};
            nibble_pkg::LATCH_OFS: rd_mux = {26'h0, il_r};
            nibble_pkg::PORT_OFS:  rd_mux = port_r;
            nibble_pkg::PIN_OFS:   rd_mux = pin_s_r;
            default:               rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wait_r <= 1'b0;
         ack_r  <= 1'b0;
         dat_r  <= 32'h0000_0000;
      end else if (ack_r || !(i_wb_cyc && i_wb_stb)) begin
         wait_r <= 1'b0;
         ack_r  <= 1'b0;
      end else if (!wait_r) begin
         wait_r <= 1'b1;
      end else begin
         ack_r <= 1'b1;
         dat_r <= rd_mux;
      end
   end

   // Memory: core owns it while running; bus writes need lane 0
   assign ram_we    = (commit && mem_we_x) || (wb_wr && idle && hit_mem && i_wb_sel[0]);
   assign ram_waddr = idle ? i_wb_adr[9:2] : {h_r, l_r};
   assign ram_wdata = idle ? i_wb_dat[3:0] : mem_wd;
   assign ram_raddr = idle ? i_wb_adr[9:2] : {h_r, l_r};

   nibble_ram #(
      .AW (8),
      .DW (4)
   ) u_ram (
      .i_clk   (i_clk),
      .i_we    (ram_we),
      .i_waddr (ram_waddr),
      .i_wdata (ram_wdata),
      .i_raddr (ram_raddr),
      .o_rdata (mem_q)
   );

   assign o_wb_dat    = dat_r;
   assign o_wb_ack    = ack_r;
   assign o_busy      = st_r[1];
   assign o_flags     = fl_r;
   assign o_int_latch = il_r;
   assign o_ime       = ime_r;
   assign o_port      = port_r;

   // Checks
   always_ff @(posedge i_clk) begin
      if (i_rst || idle) begin
         len_r <= 5'd0;
      end else begin
         len_r <= len_r + 5'd1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_run_length: assert property (commit |-> len_r == (two_cyc ? 5'd15 : 5'd7))
      else $error("instruction length wrong");
   a_addl_result: assert property (commit && op_r == nibble_pkg::OP_EXT
         && arg_r[7:4] == nibble_pkg::X_ADDL |=> {~fl_r.sf, l_r} == $past(sum_l))
      else $error("add to L wrong");
   a_reverse_subtract_carry_acc: assert property (commit && op_r == nibble_pkg::OP_REVERSE_SUBTRACT_CARRY
         |=> {~fl_r.cf, acc_r} == $past(d_rc) && fl_r.sf == fl_r.cf)
      else $error("reverse subtract with carry wrong");
   a_and_flags: assert property (commit && op_r == nibble_pkg::OP_EXT
         && arg_r[7:4] == nibble_pkg::X_AND_A
         |=> acc_r == ($past(acc_r) & $past(imm)) && fl_r.sf == (acc_r != 4'h0))
      else $error("and immediate wrong");
   a_xor_carry_hold: assert property (commit && op_r == nibble_pkg::OP_XOR_M
         |=> $stable(fl_r.cf) && fl_r.zf == (acc_r == 4'h0))
      else $error("xor disturbed carry");
   a_acc_bit_test: assert property (commit && op_r[7:2] == nibble_pkg::TA_PFX
         |=> fl_r.sf == !$past(ta_bit))
      else $error("accumulator bit test wrong");
   a_true_bit_test_zero: assert property (commit && op_r == nibble_pkg::OP_TRUE_BIT_TEST_ZF
         |=> fl_r.sf == $past(fl_r.zf) && $stable(fl_r.zf) && $stable(fl_r.cf))
      else $error("zero flag transfer wrong");
   a_gf_set: assert property (commit && op_r == nibble_pkg::OP_SET_GF
         |=> fl_r.gf && fl_r.sf && !o_busy)
      else $error("general flag set wrong");
   a_port_set_l: assert property (commit && op_r == nibble_pkg::OP_SET_L
         |=> o_port == ($past(port_r) | (32'h1 << $past(l_idx))))
      else $error("indexed port set wrong");
   a_latch_clear: assert property (commit && op_r == nibble_pkg::OP_ILCLR
         |=> o_int_latch == (($past(il_r) & $past(il_mask)) | $past(i_latch_set)))
      else $error("latch clear wrong");

   c_ext_op: cover property (commit && op_r == nibble_pkg::OP_EXT);
   c_il_ei: cover property (commit && op_r == nibble_pkg::OP_ILCLR
         && arg_r[7:6] == nibble_pkg::IL_EI);
   c_test_l: cover property (commit && op_r == nibble_pkg::OP_TEST_L);
   c_bus_ack: cover property (o_wb_ack && !o_busy);
endmodule

/* rtl/nibble_pkg.sv */
// Constants, types and helpers for the nibble execution block.
// Assumes one 20 MHz clock and a classic Wishbone register slave.
package nibble_pkg;
   // Register map, byte addresses
   localparam int          WB_AW       = 12;
   localparam logic [11:0] CMD_OFS     = 12'h000;
   localparam logic [11:0] CORE_OFS    = 12'h004;
   localparam logic [11:0] LATCH_OFS   = 12'h008;
   localparam logic [11:0] PORT_OFS    = 12'h00C;
   localparam logic [11:0] PIN_OFS     = 12'h010;
   localparam int          MEM_SEL_BIT = 10;
   localparam int          CMD_BUSY    = 16;
   localparam int          CORE_L      = 4;
   localparam int          CORE_H      = 8;
   localparam int          CORE_FLG    = 16;
   localparam int          CORE_IME    = 20;
   // Timing
   localparam int          MC_CLKS     = 2;
   localparam int          IC_MCS      = 4;
   // Opcodes
   localparam logic [7:0]  OP_EXT      = 8'h38;
   localparam logic [7:0]  OP_PORTBIT  = 8'h3B;
   localparam logic [7:0]  OP_ILCLR    = 8'h36;
   localparam logic [7:0]  OP_TEST_L   = 8'h37;
   localparam logic [7:0]  OP_SET_L    = 8'h34;
   localparam logic [7:0]  OP_CLR_L    = 8'h35;
   localparam logic [7:0]  OP_REVERSE_SUBTRACT_CARRY    = 8'h14;
   localparam logic [7:0]  OP_OR_M     = 8'h1D;
   localparam logic [7:0]  OP_XOR_M    = 8'h1F;
   localparam logic [7:0]  OP_ROTATE_LEFT_CARRY     = 8'h05;
   localparam logic [7:0]  OP_ROTATE_RIGHT_CARRY     = 8'h07;
   localparam logic [7:0]  OP_TRUE_BIT_TEST_ZF = 8'h0E;
   localparam logic [7:0]  OP_TRUE_BIT_TEST_GF = 8'h01;
   localparam logic [7:0]  OP_SET_GF   = 8'h03;
   localparam logic [7:0]  OP_CLR_GF   = 8'h02;
   localparam logic [5:0]  TA_PFX      = 6'h17;
   localparam logic [5:0]  TM_PFX      = 6'h16;
   // Second-byte sub-codes
   localparam logic [3:0]  X_ADDL      = 4'h8;
   localparam logic [3:0]  X_REVERSE_SUBTRACT_A    = 4'h1;
   localparam logic [3:0]  X_REVERSE_SUBTRACT_M    = 4'h5;
   localparam logic [3:0]  X_AND_A     = 4'h3;
   localparam logic [3:0]  X_OR_M      = 4'hA;
   localparam logic [1:0]  PB_INV      = 2'h2;
   localparam logic [1:0]  PB_TRUE     = 2'h3;
   localparam logic [1:0]  IL_PLAIN    = 2'h3;
   localparam logic [1:0]  IL_EI       = 2'h1;
   localparam logic [1:0]  IL_DI       = 2'h2;

   typedef struct packed {
      logic gf;
      logic sf;
      logic zf;
      logic cf;
   } flags_s;

   localparam flags_s      FLAGS_RST   = 4'h4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } state_e;

   function automatic logic is_zero(input logic [3:0] v);
      return (v == 4'h0);
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

/* rtl/nibble_ram.sv */
// Nibble-wide data memory, one write and one registered read port.
// Assumes the caller arbitrates who writes.
`timescale 1ns/1ps
module nibble_ram #(
   parameter int AW = 8,
   parameter int DW = 4
) (
   // Clock
   input  wire logic          i_clk,
   // Write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   // Read port
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      o_rdata <= mem[i_raddr];
   end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the nibble execution block.
// Drives the Wishbone slave, latch pulses and pins itself; no far-side model.
`timescale 1ns/1ps
module tb_top;
   logic               i_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_busy, o_ime;
   logic [11:0]        i_wb_adr;
   logic [3:0]         i_wb_sel;
   logic [31:0]        i_wb_dat, o_wb_dat, i_port_pin, o_port, rd_d;
   logic [5:0]         i_latch_set, o_int_latch;
   nibble_pkg::flags_s o_flags;
   int                 n_fail, n_compared, cyc_n, blen;

   typedef struct packed {
      logic [20:0] cin;
      logic [3:0]  min;
      logic [15:0] op;
      logic [20:0] cexp;
      logic [3:0]  mexp;
      logic [4:0]  len;
   } row_s;

   // Core word: [20] ime, [19:16] gf sf zf cf, [11:8] H, [7:4] L, [3:0] acc
   localparam row_s TBL[24] = '{
      '{21'h0000E0,4'h0,16'h8238,21'h020000,4'h0,5'h10},
      '{21'h000010,4'h0,16'h8238,21'h040030,4'h0,5'h10},
      '{21'h010235,4'h7,16'h1038,21'h01023B,4'h7,5'h10},
      '{21'h010235,4'h7,16'h1F38,21'h05023A,4'h7,5'h10},
      '{21'h010233,4'h7,16'h0014,21'h050234,4'h7,5'h08},
      '{21'h040237,4'h7,16'h0014,21'h00023F,4'h7,5'h08},
      '{21'h040230,4'h7,16'h5038,21'h000230,4'h9,5'h10},
      '{21'h000230,4'h7,16'h5F38,21'h040230,4'h8,5'h10},
      '{21'h04023A,4'h0,16'h3538,21'h020230,4'h0,5'h10},
      '{21'h040230,4'h0,16'h001D,21'h020230,4'h0,5'h08},
      '{21'h020230,4'h7,16'hA838,21'h040230,4'hF,5'h10},
      '{21'h020236,4'h7,16'h001F,21'h040231,4'h7,5'h08},
      '{21'h040237,4'h7,16'h001F,21'h020230,4'h7,5'h08},
      '{21'h040234,4'h0,16'h005E,21'h000234,4'h0,5'h08},
      '{21'h000234,4'h0,16'h005C,21'h040234,4'h0,5'h08},
      '{21'h000230,4'h7,16'h005B,21'h040230,4'h7,5'h08},
      '{21'h040230,4'h7,16'h0059,21'h000230,4'h7,5'h08},
      '{21'h020230,4'h0,16'h000E,21'h060230,4'h0,5'h08},
      '{21'h080230,4'h0,16'h0001,21'h0C0230,4'h0,5'h08},
      '{21'h000230,4'h0,16'h0003,21'h0C0230,4'h0,5'h08},
      '{21'h080230,4'h0,16'h0002,21'h040230,4'h0,5'h08},
      '{21'h000239,4'h0,16'h0005,21'h010232,4'h0,5'h08},
      '{21'h000239,4'h0,16'h0007,21'h010234,4'h0,5'h08},
      '{21'h05023A,4'h0,16'h0000,21'h05023A,4'h0,5'h08}};

   // Port 5 is an output (reads register), port 1 an input (reads pin)
   localparam logic [15:0] POP[6] = '{16'h0034,16'h0035,16'h0037,16'hA53B,16'hE53B,16'hD13B};
   localparam logic [5:0]  SEXP   = 6'h28;

   nibble_alu_bit_test_decode #(.PORT_OUT_MASK(8'hF0)) DUT (
      .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_latch_set(i_latch_set),
      .i_port_pin(i_port_pin), .o_port(o_port), .o_busy(o_busy), .o_flags(o_flags),
      .o_int_latch(o_int_latch), .o_ime(o_ime));

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   task automatic summarize();
      $display("compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Whole run needs about 1000 cycles
   always @(posedge i_clk) begin
      cyc_n++;
      if (cyc_n == 8000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", s, e, g);
         n_fail++;
      end
   endtask

   // Request held until ack is sampled high
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do @(posedge i_clk); while (o_wb_ack !== 1'b1);
      rd_d = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask

   // Busy is counted edge by edge, so a wrong cycle count shows
   task automatic ex(input logic [15:0] op);
      bus(1'b1, nibble_pkg::CMD_OFS, {16'h0000, op});
      blen = 0;
      // Command lands at the ack edge, so busy shows from the next edge
      @(posedge i_clk);
      while (o_busy === 1'b1 && blen < 40) begin
         blen++;
         @(posedge i_clk);
      end
   endtask

   function automatic logic [11:0] hl_adr(input logic [20:0] c);
      return 12'h400 | {2'b00, c[11:4], 2'b00};
   endfunction

   initial begin
      i_rst = 1'b1;
      {i_wb_cyc, i_wb_stb, i_wb_we} = 3'h0;
      i_wb_adr = 12'h000;
      i_wb_sel = 4'hF;
      i_wb_dat = 32'h0;
      i_latch_set = 6'h00;
      i_port_pin = 32'h0;
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      chk("reset flags", 32'h4, {28'h0, o_flags});
      chk("reset state", 32'h0, {25'h0, o_ime, o_int_latch} | o_port);
      bus(1'b0, 12'h020, 32'h0);
      chk("unmapped read", 32'h0, rd_d);
      bus(1'b1, nibble_pkg::LATCH_OFS, 32'h3F);
      bus(1'b0, nibble_pkg::LATCH_OFS, 32'h0);
      chk("latch read only", 32'h0, rd_d & 32'h3F);
      $display("test bus done");
      foreach (TBL[i]) begin
         bus(1'b1, nibble_pkg::CORE_OFS, {11'h000, TBL[i].cin});
         bus(1'b1, hl_adr(TBL[i].cin), {28'h0, TBL[i].min});
         ex(TBL[i].op);
         chk("busy length", {27'h0, TBL[i].len}, blen);
         bus(1'b0, nibble_pkg::CORE_OFS, 32'h0);
         chk("core", {11'h000, TBL[i].cexp}, rd_d & 32'h001F0FFF);
         bus(1'b0, hl_adr(TBL[i].cin), 32'h0);
         chk("memory", {28'h0, TBL[i].mexp}, rd_d & 32'hF);
      end
      $display("test alu table done");
      i_port_pin <= 32'h00400020;
      bus(1'b1, nibble_pkg::CORE_OFS, 32'h00000060);
      foreach (POP[i]) begin
         ex(POP[i]);
         chk("port", (i == 0) ? 32'h00400000 : 32'h0, o_port);
         if (i >= 2) chk("port test", {31'h0, SEXP[i]}, {31'h0, o_flags.sf});
      end
      $display("test port bits done");
      i_latch_set <= 6'h3F;
      @(posedge i_clk);
      i_latch_set <= 6'h00;
      ex(16'hEA36);
      chk("latch clear", 32'h2A, {25'h0, o_ime, o_int_latch});
      ex(16'h4F36);
      chk("latch enable", 32'h4A, {25'h0, o_ime, o_int_latch});
      ex(16'h8036);
      chk("latch disable", 32'h00, {25'h0, o_ime, o_int_latch});
      $display("test latches done");
      summarize();
   end
endmodule
